// *** design/pbs_sram_port.sv ***
//----------------------------------------------------------------------
// Pipelined burst SRAM port
//----------------------------------------------------------------------
// Purpose: synchronous pipelined burst SRAM with byte-lane writes
// Assumes: bus inputs are synchronous to mclk_i; output enable,
//          sleep and burst order pins are asynchronous
// Notes:   data pin is split into dq_i, dq_o and dq_oe_o
// What this block does
// (R1) Every synchronous input is registered on the rising clock edge.
// (R2) Address and chip selects load only when an address strobe is low.
// (R3) Follow-on burst addresses are made inside, stepped by advance.
// (R4) The burst counter is two bits, covering at most four words.
// (R5) Interleaved or linear burst order is picked by a static input.
// (R6) Write address, data and controls are registered, then written.
// (R7) Lane selects with the lane write enable pick the written lanes.
// (R8) A low all-lanes write input writes every lane of the word.
// (R9) Output enable and sleep act without the clock; enable gates dq.
// (R10) Inputs and read data are registered, one stage apart.
// (R11) Bursts run at three cycles for the first word then one each.
// (R12) A deselect through the chip selects takes one clock cycle.
// (R13) A processor strobe and a controller strobe both start access.
// (R14) The array holds 262,144 words of 36 bits in this build.
// (R15) A sleep input puts the memory into an idle low-power mode.
// (R16) The counter changes only the two low bits within its block.
// (R17) Each lane select covers eight data bits and one parity bit.
`timescale 1ns/1ps
module pbs_sram_port (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Address and strobes
  input wire logic [pbs_pkg::ADDR_W-1:0] addr_i,
  input wire logic processor_addr_strobe_n_i,
  input wire logic controller_addr_strobe_n_i,
  input wire logic burst_advance_n_i,
  // Chip selects
  input wire logic chip_select_pipeline_n_i,
  input wire logic chip_select_depth_hi_i,
  input wire logic chip_select_depth_n_i,
  // Write controls
  input wire logic [pbs_pkg::LANES-1:0] lane_write_select_n_i,
  input wire logic lane_write_enable_n_i,
  input wire logic all_lanes_write_n_i,
  // Asynchronous controls
  input wire logic output_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_linear_i,
  // Data pin
  input wire logic [pbs_pkg::DATA_W-1:0] dq_i,
  output logic [pbs_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o
);

  //--------------------------------------------------------------------
  // Input registers
  //--------------------------------------------------------------------
  logic [pbs_pkg::ADDR_W-1:0] addr_r;
  logic [pbs_pkg::DATA_W-1:0] din_r;
  logic processor_addr_strobe_n_n_r, controller_addr_strobe_n_n_r, adv_n_r;
  logic cs_pipe_n_r, cs_hi_r, cs_lo_n_r;
  logic [pbs_pkg::LANES-1:0] lane_sel_n_r;
  logic lane_en_n_r, all_n_r;

  // (R1) capture bus inputs
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_r <= pbs_pkg::ADDR_RST;
      din_r <= pbs_pkg::DATA_RST;
      processor_addr_strobe_n_n_r <= 1'b1;
      controller_addr_strobe_n_n_r <= 1'b1;
      adv_n_r <= 1'b1;
      cs_pipe_n_r <= 1'b1;
      cs_hi_r <= 1'b0;
      cs_lo_n_r <= 1'b1;
      lane_sel_n_r <= pbs_pkg::LANES_ALL;
      lane_en_n_r <= 1'b1;
      all_n_r <= 1'b1;
    end else begin
      addr_r <= addr_i;
      din_r <= dq_i;
      processor_addr_strobe_n_n_r <= processor_addr_strobe_n_i;
      controller_addr_strobe_n_n_r <= controller_addr_strobe_n_i;
      adv_n_r <= burst_advance_n_i;
      cs_pipe_n_r <= chip_select_pipeline_n_i;
      cs_hi_r <= chip_select_depth_hi_i;
      cs_lo_n_r <= chip_select_depth_n_i;
      lane_sel_n_r <= lane_write_select_n_i;
      lane_en_n_r <= lane_write_enable_n_i;
      all_n_r <= all_lanes_write_n_i;
    end
  end

  //--------------------------------------------------------------------
  // Asynchronous pin synchronisers
  //--------------------------------------------------------------------
  logic sleep_meta_r, sleep_r, lin_meta_r, lin_r;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sleep_meta_r <= 1'b0;
      sleep_r <= 1'b0;
      lin_meta_r <= 1'b0;
      lin_r <= 1'b0;
    end else begin
      sleep_meta_r <= sleep_request_i;
      sleep_r <= sleep_meta_r;
      lin_meta_r <= burst_linear_i;
      lin_r <= lin_meta_r;
    end
  end

  //--------------------------------------------------------------------
  // Address load and burst counter
  //--------------------------------------------------------------------
  logic [pbs_pkg::ADDR_W-1:0] base_r, base_nxt, cur_addr;
  logic [pbs_pkg::BURST_W-1:0] cnt_r, cnt_nxt, low_bits;
  logic sel_r, sel_nxt, strobe, cs_in, step;

  // (R13) either strobe starts
  assign strobe = !processor_addr_strobe_n_n_r || !controller_addr_strobe_n_n_r;
  assign cs_in = !cs_pipe_n_r && cs_hi_r && !cs_lo_n_r;
  // (R3) advance steps burst
  assign step = !strobe && !adv_n_r && sel_r;

  always_comb begin
    base_nxt = base_r;
    cnt_nxt = cnt_r;
    sel_nxt = sel_r;
    // (R2) load on strobe only
    if (strobe) begin
      base_nxt = addr_r;
      cnt_nxt = pbs_pkg::BURST_RST;
      sel_nxt = cs_in;
    end else if (step) begin
      // (R4) two-bit wrapping counter
      cnt_nxt = cnt_r + pbs_pkg::BURST_STEP;
    end
    // (R5) burst order select
    if (lin_r) begin
      low_bits = base_nxt[pbs_pkg::BURST_W-1:0] + cnt_nxt;
    end else begin
      low_bits = base_nxt[pbs_pkg::BURST_W-1:0] ^ cnt_nxt;
    end
    // (R16) upper bits kept
    cur_addr = {base_nxt[pbs_pkg::ADDR_W-1:pbs_pkg::BURST_W], low_bits};
  end

  // (R12) deselect in one cycle
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      base_r <= pbs_pkg::ADDR_RST;
      cnt_r <= pbs_pkg::BURST_RST;
      sel_r <= 1'b0;
    end else begin
      base_r <= base_nxt;
      cnt_r <= cnt_nxt;
      sel_r <= sel_nxt;
    end
  end

  //--------------------------------------------------------------------
  // Array and lane writes
  //--------------------------------------------------------------------
  // (R14) wide organisation array
  logic [pbs_pkg::DATA_W-1:0] mem [pbs_pkg::DEPTH];
  logic [pbs_pkg::LANES-1:0] lane_we;
  logic [pbs_pkg::DATA_W-1:0] wr_word;
  logic write_now, read_now;

  always_comb begin
    // (R8) all lanes on global write
    if (!all_n_r) begin
      lane_we = pbs_pkg::LANES_ALL;
    // (R7) per-lane selects
    end else if (!lane_en_n_r) begin
      lane_we = ~lane_sel_n_r;
    end else begin
      lane_we = pbs_pkg::LANES_NONE;
    end
  end

  // (R15) sleep blocks access
  // A processor strobe cycle never writes; it reads unless deselected or asleep
  assign write_now = sel_nxt && !sleep_r && processor_addr_strobe_n_n_r && (lane_we != '0);
  assign read_now = sel_nxt && !sleep_r && !write_now;

  // (R17) nine-bit lanes incl parity
  // Unselected lanes keep the stored bits; one process owns the array
  for (genvar g = 0; g < pbs_pkg::LANES; g++) begin : g_lane
    assign wr_word[g*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] = lane_we[g] ?
      din_r[g*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] :
      mem[cur_addr][g*pbs_pkg::LANE_W +: pbs_pkg::LANE_W];
  end

  // (R6) self-timed lane write
  always_ff @(posedge mclk_i) begin
    if (write_now) begin
      mem[cur_addr] <= wr_word;
    end
  end

  //--------------------------------------------------------------------
  // Read pipeline and output drive
  //--------------------------------------------------------------------
  logic rd_valid_r;

  // (R10) registered read data
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dq_o <= pbs_pkg::DATA_RST;
    end else if (read_now) begin
      dq_o <= mem[cur_addr];
    end
  end

  // (R11) one word per cycle
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= read_now;
    end
  end

  // (R9) asynchronous output gate
  assign dq_oe_o = rd_valid_r && !output_enable_n_i && !sleep_request_i;

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  input_cap_a: // (R1)
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      1'b1 |=> addr_r == $past(addr_i) && din_r == $past(dq_i))
    else $error("bus inputs not captured");

  strobe_load_a: // (R2)
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      strobe |=> base_r == $past(addr_r) && cnt_r == 2'h0)
    else $error("address not loaded on strobe");

  burst_hold_a: // (R3)
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !strobe && adv_n_r |=> base_r == $past(base_r) && $stable(cnt_r))
    else $error("burst moved without advance");

  burst_step_a: // (R4)
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      step |=> cnt_r == $past(cnt_r) + 2'h1)
    else $error("burst counter did not step");

  order_low_a: // (R5)
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !lin_r |-> cur_addr[1:0] == (base_nxt[1:0] ^ cnt_nxt))
    else $error("interleaved order wrong");

  upper_kept_a: // (R16)
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !strobe |-> cur_addr[17:2] == base_r[17:2])
    else $error("burst touched upper address bits");

  all_lanes_a: // (R8)
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !all_n_r |-> lane_we == 4'hF)
    else $error("global write missed a lane");

  lane_pick_a: // (R7)
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      all_n_r && !lane_en_n_r |-> lane_we == ~lane_sel_n_r)
    else $error("lane enables wrong");

  deselect_a: // (R12)
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      strobe && !cs_in |=> !sel_r && !rd_valid_r)
    else $error("deselect took more than one cycle");

  read_pipe_a: // (R10)
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      read_now |=> rd_valid_r && dq_o == $past(mem[cur_addr]))
    else $error("read data not one stage later");

  sleep_idle_a: // (R15)
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      sleep_r |=> !rd_valid_r)
    else $error("access during sleep");

  oe_gate_a: // (R9)
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      output_enable_n_i || sleep_request_i |-> !dq_oe_o)
    else $error("driver on while disabled");

endmodule

// *** design/pbs_pkg.sv ***
//----------------------------------------------------------------------
// Purpose: Shared constants for the pipelined burst SRAM port
//----------------------------------------------------------------------
// Purpose: geometry, lane layout and reset values
// Assumes: the wide (36-bit) organisation is the one built
// Notes:   the narrow organisation is kept for reference only
package pbs_pkg;
  // Wide organisation: 262,144 words of 36 bits
  localparam int ADDR_W = 18;
  localparam int DEPTH = 262144;
  localparam int DATA_W = 36;
  // Narrow organisation: 524,288 words of 18 bits
  localparam int NARROW_ADDR_W = 19;
  localparam int NARROW_DEPTH = 524288;
  localparam int NARROW_DATA_W = 18;
  // Each lane is eight data bits plus one parity bit
  localparam int LANE_W = 9;
  localparam int LANES = DATA_W / LANE_W;
  localparam int NARROW_LANES = NARROW_DATA_W / LANE_W;
  localparam int PARITY_POS = 8;
  // Burst counter field: the two lowest address bits
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
  localparam logic [LANES-1:0] LANES_ALL = 4'hF;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
endpackage

// *** testbench/pbs_host.sv ***
// Purpose: bus controller model for the burst SRAM port
// Assumes: outputs change by non-blocking assignment at the edge
// Notes:   an idle data bus shows the inverse of its last value
`timescale 1ns/1ps
module pbs_host (
  // Clock
  input wire logic mclk_i,
  // Bus
  output logic [pbs_pkg::ADDR_W-1:0] addr_o,
  output logic pstb_n_o,
  output logic cstb_n_o,
  output logic step_n_o,
  output logic [2:0] sel_o,
  output logic [5:0] wr_o,
  output logic [pbs_pkg::DATA_W-1:0] wdata_o
);
  initial begin
    addr_o = '0;
    pstb_n_o = 1'h1;
    cstb_n_o = 1'h1;
    step_n_o = 1'h1;
    sel_o = 3'h6;
    wr_o = 6'h3F;
    wdata_o = '0;
  end
  task automatic drive(input int k,
      input logic [pbs_pkg::ADDR_W-1:0] a, input logic st_n,
      input logic [2:0] s, input logic [5:0] w,
      input logic [pbs_pkg::DATA_W-1:0] d);
    @(posedge mclk_i);
    pstb_n_o <= (k != 1);
    cstb_n_o <= (k != 2);
    step_n_o <= st_n;
    addr_o <= a;
    sel_o <= s;
    wr_o <= w;
    wdata_o <= d;
  endtask
  // Deselect strobe; released data inverted
  task automatic idle();
    drive(2, addr_o, 1'h1, 3'h6, 6'h3F, ~wdata_o);
  endtask
endmodule

// *** testbench/tb_top.sv ***
// Purpose: self-checking bench for the burst SRAM port
// Assumes: host model drives the bus at the rising edge
// Notes:   a local word table predicts every read
`timescale 1ns/1ps
module tb_top;
  logic mclk, rst_n, lin, oe_n, slp, pstb_n, cstb_n, step_n, drv;
  logic [pbs_pkg::ADDR_W-1:0] addr;
  logic [2:0] sel;
  logic [5:0] wr;
  logic [pbs_pkg::DATA_W-1:0] wdata, rdata;
  logic [pbs_pkg::DATA_W-1:0] mem [0:pbs_pkg::DEPTH-1];
  logic [pbs_pkg::DATA_W-1:0] expq [$];
  // Note at an edge, drive at the next, capture, output, then half a period
  localparam int READ_DUE = 350;
  time dueq [$];
  integer seed;
  int mismatches, num_checks, b;

  pbs_host u_host (
    .mclk_i(mclk), .addr_o(addr), .pstb_n_o(pstb_n), .cstb_n_o(cstb_n),
    .step_n_o(step_n), .sel_o(sel), .wr_o(wr), .wdata_o(wdata));
  pbs_sram_port dut (
    .mclk_i(mclk), .reset_n_i(rst_n), .addr_i(addr),
    .processor_addr_strobe_n_i(pstb_n),
    .controller_addr_strobe_n_i(cstb_n), .burst_advance_n_i(step_n),
    .chip_select_pipeline_n_i(sel[2]), .chip_select_depth_hi_i(sel[1]),
    .chip_select_depth_n_i(sel[0]), .lane_write_select_n_i(wr[3:0]),
    .lane_write_enable_n_i(wr[4]), .all_lanes_write_n_i(wr[5]),
    .output_enable_n_i(oe_n), .sleep_request_i(slp),
    .burst_linear_i(lin), .dq_i(wdata), .dq_o(rdata), .dq_oe_o(drv));

  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  task automatic check(input logic [pbs_pkg::DATA_W-1:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  function automatic int nxt(int a, int c);
    return (a & ~3) | (lin ? (a + c) & 3 : (a ^ c) & 3);
  endfunction

  // Drive one burst, note each expected read
  task automatic burst(int k, int a0, logic [5:0] w, logic [2:0] s, int n);
    logic [pbs_pkg::DATA_W-1:0] d;
    logic [3:0] m;
    int a;
    for (int c = 0; c < n; c++) begin
      d = 36'({$random(seed), $random(seed)});
      a = nxt(a0, c);
      m = !w[5] ? 4'hF : (!w[4] ? ~w[3:0] : 4'h0);
      if (c == 0 && k == 1)
        m = 4'h0;
      if (s == 3'h2 && !slp) begin
        if (m != 4'h0) begin
          for (int g = 0; g < 4; g++)
            if (m[g])
              mem[a][9*g +: 9] = d[9*g +: 9];
        end else if (!oe_n) begin
          expq.push_back(mem[a]);
          dueq.push_back($time + READ_DUE);
        end
      end
      u_host.drive(c == 0 ? k : 0, a0[17:0], c == 0, s, w, d);
    end
    u_host.idle();
  endtask

  // Every driven word must have been noted
  always @(negedge mclk) begin
    if (drv !== 1'h0) begin
      if (expq.size() == 0)
        check(36'(drv), 36'h0);
      else begin
        check(rdata, expq.pop_front());
        check(36'($time), 36'(dueq.pop_front()));
      end
    end
  end

  initial begin
    seed = 32'hcf97;
    mismatches = 0;
    num_checks = 0;
    rst_n = 1'h0;
    lin = 1'h0;
    oe_n = 1'h0;
    slp = 1'h0;
    repeat (20) @(posedge mclk);
    check(rdata, 36'h0);
    rst_n <= 1'h1;
    for (int t = 0; t < 8; t++) begin
      b = $random(seed) & 32'h3FFFC;
      lin <= t[0];
      repeat (3) u_host.idle();
      burst(2, b, 6'h1F, 3'h2, 4);
      burst(2, b + t % 4, {2'h2, 4'($random(seed))}, 3'h2, 1);
      burst(1 + t[1], b + t % 4, {2'h3, 4'($random(seed))}, 3'h2, 4);
      burst(1, b, 6'h1F, 3'h2, 1);
      burst(2, b + 1, 6'h1F, 3'h2 ^ (3'h1 << t % 3), 1);
      burst(2, b + 1, 6'h3F, 3'h2, 1);
    end
    repeat (3) u_host.idle();
    slp <= 1'h1;
    repeat (3) u_host.idle();
    burst(2, b, 6'h1F, 3'h2, 2);
    slp <= 1'h0;
    oe_n <= 1'h1;
    repeat (3) u_host.idle();
    burst(1, b, 6'h3F, 3'h2, 2);
    repeat (3) u_host.idle();
    oe_n <= 1'h0;
    u_host.idle();
    burst(1, b, 6'h3F, 3'h2, 4);
    repeat (3) u_host.idle();
    check(36'(expq.size()), 36'h0);
    tally_and_finish();
  end

  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
endmodule
